// ### rtl/wdt_pkg.sv
// Constants, field layout and types shared by the watchdog design files
package wdt_pkg;

   // --------------------
   // Register byte offsets
   // --------------------
   localparam logic [11:0] CFG_OFS  = 12'h000;
   localparam logic [11:0] RCTL_OFS = 12'h004;
   localparam logic [11:0] STAT_OFS = 12'h008;

   // --------------------
   // Configuration word fields
   // --------------------
   localparam int POST_LSB   = 0;
   localparam int PRE_BIT    = 4;
   localparam int EN_LSB     = 5;
   localparam int WINDOW_DISABLE_BIT_BIT = 7;
   localparam int WIN_LSB    = 8;
   localparam int CFG_W      = 10;
   localparam logic [CFG_W-1:0] CFG_RST = 10'h080;

   // --------------------
   // Reset control register fields
   // --------------------
   localparam int IDLE_BIT  = 2;
   localparam int SLEEP_BIT = 3;
   localparam int TO_BIT    = 4;
   localparam int SWEN_BIT  = 5;

   // --------------------
   // Status register fields
   // --------------------
   localparam int STAT_RUN_BIT  = 24;
   localparam int STAT_WIN_BIT  = 25;
   localparam int STAT_MODE_LSB = 28;

   // --------------------
   // Timing
   // --------------------
   localparam int unsigned CLK_HZ   = 25_000_000;
   localparam int unsigned LOW_POWER_RC_OSC_HZ  = 32_000;
   localparam int unsigned LOW_POWER_RC_OSC_DIV = CLK_HZ / LOW_POWER_RC_OSC_HZ;
   localparam int PRE_LOG_32  = 5;
   localparam int PRE_LOG_128 = 7;
   localparam int CNT_W       = 22;

   // --------------------
   // Enable field codes and power modes
   // --------------------
   localparam logic [1:0] EN_OFF    = 2'b00;
   localparam logic [1:0] EN_ACTIVE = 2'b01;
   localparam logic [1:0] EN_SOFT   = 2'b10;
   localparam logic [1:0] EN_HW     = 2'b11;

   typedef enum logic [1:0] {
      MODE_RUN   = 2'b00,
      MODE_SLEEP = 2'b01,
      MODE_IDLE  = 2'b10
   } pwr_mode_t;

endpackage

// ### rtl/low_power_rc_osc_tick_gen.sv
// Low-power RC oscillator model: one-cycle tick at the nominal 32 kHz rate
module low_power_rc_osc_tick_gen #(
   parameter int unsigned DIV = 781
) (
   // Clock and reset
   input  wire logic hclk,
   input  wire logic hresetn,
   // Oscillator on, tick out
   input  wire logic osc_on,
   output logic      tick
);

   localparam int W = $clog2(DIV);

   logic [W-1:0] cnt_r;
   logic         tick_r;

   // Divider runs only while the oscillator is switched on
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_r  <= '0;
         tick_r <= 1'b0;
      end else if (!osc_on) begin
         cnt_r  <= '0;
         tick_r <= 1'b0;
      end else if (cnt_r == W'(DIV - 1)) begin
         cnt_r  <= '0;
         tick_r <= 1'b1;
      end else begin
         cnt_r  <= cnt_r + 1'b1;
         tick_r <= 1'b0;
      end
   end

   assign tick = tick_r;

endmodule

// ### rtl/wdt_scaler.sv
// Prescaler, postscaler and window compare of the watchdog
module wdt_scaler #(
   parameter int CNT_W = 22
) (
   // Clock and reset
   input  wire logic             hclk,
   input  wire logic             hresetn,
   // Count control
   input  wire logic             tick,
   input  wire logic             clear,
   // Configuration
   input  wire logic             pre_sel,
   input  wire logic [3:0]       post_sel,
   input  wire logic [1:0]       win_sel,
   // Results
   output logic                  timeout,
   output logic                  win_open,
   output logic [CNT_W-1:0]      count
);

   logic [CNT_W-1:0] cnt_r;
   logic             timeout_r;
   logic [CNT_W:0]   per;
   logic [CNT_W:0]   thr;

   // Period in oscillator ticks: prescale times power-of-two postscale
   // select one means 128
   function automatic logic [CNT_W:0] period_f(input logic pre, input logic [3:0] post);
      int sh;
      sh = (pre ? wdt_pkg::PRE_LOG_128 : wdt_pkg::PRE_LOG_32) + int'(post);
      return (CNT_W+1)'(1) << sh;
   endfunction

   // Closed part of the period in eighths, from the window size
   function automatic logic [2:0] closed_eighths_f(input logic [1:0] w);
      case (w)
         2'b11:   return 3'd6;
         2'b10:   return 3'd5;
         2'b01:   return 3'd4;
         default: return 3'd2;
      endcase
   endfunction

   assign per = period_f(pre_sel, post_sel);
   assign thr = (CNT_W+1)'((per >> 3) * closed_eighths_f(win_sel));
   assign win_open = {1'b0, cnt_r} >= thr;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_r     <= '0;
         timeout_r <= 1'b0;
      end else if (clear) begin
         cnt_r     <= '0;
         timeout_r <= 1'b0;
      end else if (tick && ({1'b0, cnt_r} == per - 1'b1)) begin
         cnt_r     <= '0;
         timeout_r <= 1'b1;
      end else begin
         cnt_r     <= tick ? cnt_r + 1'b1 : cnt_r;
         timeout_r <= 1'b0;
      end
   end

   assign timeout = timeout_r;
   assign count   = cnt_r;

endmodule

// ### rtl/low_power_rc_osc_watchdog_timer.sv
// Watchdog timer top: AHB-Lite registers, enable, power modes and reset request
//
// How it works
// - Watchdog counts low-power RC ticks; oscillator is on while enabled.
// - Nominal 32 kHz clock is prescaled by 32 or 128.
// - Prescale select one gives divide by 128, zero gives 32.
// - Four-bit postscale field in low config bits further divides prescaler output.
// - Postscale code n gives ratio two to the n, up to 32768.
// - Device reset and completed clock switch clear all watchdog counts.
// - Entering Sleep or Idle clears all watchdog counts.
// - Leaving Sleep or Idle clears all watchdog counts.
// - Clear instruction in normal running clears counts; software must clear in time.
// - An enabled watchdog keeps counting in Sleep and Idle.
// - Time-out in Sleep or Idle wakes the core instead of resetting.
// - Sleep and idle flags stay set until software clears them.
// - Enable field 11 forces watchdog on; the soft enable bit cannot stop it.
// - Enable field 00 runs watchdog only while soft enable bit is set.
// - Field 01 runs in Run and Idle, stops in Sleep; field 10 follows soft enable.
// - Every device reset clears the soft enable bit.
// - Time-out sets timeout flag; only software clears it.
// - Window disable bit zero selects windowed clearing by window size.
// - Window size 11, 10, 01, 00 gives 25, 37.5, 50, 75 percent.
//
// The AHB-Lite register port and the address map were left to the implementer.
module low_power_rc_osc_watchdog_timer #(
   parameter int unsigned TICK_DIV = wdt_pkg::LOW_POWER_RC_OSC_DIV
) (
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   // Core events
   input  wire logic        clear_watchdog_instr,
   input  wire logic        power_save_instr,
   input  wire logic        power_save_idle,
   input  wire logic        wake_event,
   input  wire logic        clock_switch_done,
   // Status to the system
   output logic             low_power_rc_osc_en,
   output logic             wdt_reset_req,
   output logic             wake_req,
   output logic [1:0]       power_mode
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   localparam int CW = wdt_pkg::CNT_W;

   logic [wdt_pkg::CFG_W-1:0] cfg_r;
   logic                      soft_enable_bit_r;
   logic                      timeout_flag_r;
   logic                      sleep_flag_r;
   logic                      idle_flag_r;
   wdt_pkg::pwr_mode_t        mode_r;
   wdt_pkg::pwr_mode_t        mode_nxt;
   logic                      osc_en_r;
   logic                      reset_req_r;
   logic                      wake_req_r;
   logic                      wr_pend_r;
   logic [11:0]               addr_r;
   logic [31:0]               hrdata_r;
   logic [31:0]               rdata_nxt;

   logic [3:0]  watchdog_postscale_select;
   logic        watchdog_prescale_select;
   logic [1:0]  hw_enable_field;
   logic        window_disable_bit;
   logic [1:0]  window_size_select;

   logic          addr_phase;
   logic          wr_cfg;
   logic          wr_rctl;
   logic          in_run;
   logic          running;
   logic          osc_tick;
   logic          timeout;
   logic          win_open;
   logic [CW-1:0] count;
   logic          ps_enter;
   logic          wake_go;
   logic          clr_ok;
   logic          bad_clr;
   logic          scaler_clear;

   // ----------------------------------------------------------------
   // Configuration fields
   // ----------------------------------------------------------------
   // postscale in low bits
   assign watchdog_postscale_select = cfg_r[wdt_pkg::POST_LSB +: 4];
   assign watchdog_prescale_select  = cfg_r[wdt_pkg::PRE_BIT];
   assign hw_enable_field           = cfg_r[wdt_pkg::EN_LSB +: 2];
   assign window_disable_bit        = cfg_r[wdt_pkg::WINDOW_DISABLE_BIT_BIT];
   assign window_size_select        = cfg_r[wdt_pkg::WIN_LSB +: 2];

   // ----------------------------------------------------------------
   // AHB-Lite slave, zero wait states
   // ----------------------------------------------------------------
   assign addr_phase = hsel && hready && htrans[1];
   assign wr_cfg     = wr_pend_r && (addr_r == wdt_pkg::CFG_OFS);
   assign wr_rctl    = wr_pend_r && (addr_r == wdt_pkg::RCTL_OFS);

   // Capture address phase of writes for the following data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         addr_r    <= '0;
      end else if (hready) begin
         wr_pend_r <= addr_phase && hwrite;
         addr_r    <= addr_phase ? haddr[11:0] : addr_r;
      end
   end

   // Read mux; unmapped offsets read zero
   always_comb begin
      rdata_nxt = '0;
      case (haddr[11:0])
         wdt_pkg::CFG_OFS: begin
            rdata_nxt[wdt_pkg::CFG_W-1:0] = cfg_r;
         end
         wdt_pkg::RCTL_OFS: begin
            rdata_nxt[wdt_pkg::SWEN_BIT]  = soft_enable_bit_r;
            rdata_nxt[wdt_pkg::TO_BIT]    = timeout_flag_r;
            rdata_nxt[wdt_pkg::SLEEP_BIT] = sleep_flag_r;
            rdata_nxt[wdt_pkg::IDLE_BIT]  = idle_flag_r;
         end
         wdt_pkg::STAT_OFS: begin
            rdata_nxt[CW-1:0]                    = count;
            rdata_nxt[wdt_pkg::STAT_RUN_BIT]     = running;
            rdata_nxt[wdt_pkg::STAT_WIN_BIT]     = win_open;
            rdata_nxt[wdt_pkg::STAT_MODE_LSB +: 2] = mode_r;
         end
         default: begin
            rdata_nxt = '0;
         end
      endcase
   end

   // Read data registered at the address phase, stands in the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_r <= '0;
      end else if (addr_phase && !hwrite) begin
         hrdata_r <= rdata_nxt;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_r;

   // ----------------------------------------------------------------
   // Enable selection
   // ----------------------------------------------------------------
   assign in_run = (mode_r == wdt_pkg::MODE_RUN);

   always_comb begin
      case (hw_enable_field)
         wdt_pkg::EN_HW: running = 1'b1;
         wdt_pkg::EN_ACTIVE: running = (mode_r != wdt_pkg::MODE_SLEEP);
         wdt_pkg::EN_SOFT: running = soft_enable_bit_r;
         default: running = soft_enable_bit_r;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         osc_en_r <= 1'b0;
      end else begin
         osc_en_r <= running;
      end
   end

   low_power_rc_osc_tick_gen #(
      .DIV (TICK_DIV)
   ) u_osc (
      .hclk    (hclk),
      .hresetn (hresetn),
      .osc_on  (osc_en_r),
      .tick    (osc_tick)
   );

   // ----------------------------------------------------------------
   // Count clearing events
   // ----------------------------------------------------------------
   assign ps_enter = power_save_instr && in_run;
   assign wake_go  = !in_run && (wake_event || timeout);
   assign clr_ok   = clear_watchdog_instr && in_run;
   assign bad_clr  = clr_ok && !window_disable_bit && !win_open;

   assign scaler_clear = !running || clock_switch_done || ps_enter || wake_go || clr_ok;

   wdt_scaler #(
      .CNT_W (CW)
   ) u_scaler (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .tick     (osc_tick && running),
      .clear    (scaler_clear),
      .pre_sel  (watchdog_prescale_select),
      .post_sel (watchdog_postscale_select),
      .win_sel  (window_size_select),
      .timeout  (timeout),
      .win_open (win_open),
      .count    (count)
   );

   // ----------------------------------------------------------------
   // Power mode state machine
   // ----------------------------------------------------------------
   always_comb begin
      mode_nxt = mode_r;
      case (mode_r)
         wdt_pkg::MODE_RUN: begin
            if (ps_enter) begin
               mode_nxt = power_save_idle ? wdt_pkg::MODE_IDLE : wdt_pkg::MODE_SLEEP;
            end
         end
         wdt_pkg::MODE_SLEEP, wdt_pkg::MODE_IDLE: begin
            if (wake_go) begin
               mode_nxt = wdt_pkg::MODE_RUN;
            end
         end
         default: begin
            mode_nxt = wdt_pkg::MODE_RUN;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_r <= wdt_pkg::MODE_RUN;
      end else begin
         mode_r <= mode_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Reset control register
   // ----------------------------------------------------------------
   // reset clears soft enable
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         soft_enable_bit_r <= 1'b0;
      end else if (wr_rctl) begin
         soft_enable_bit_r <= hwdata[wdt_pkg::SWEN_BIT];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         timeout_flag_r <= 1'b0;
      end else if (timeout || bad_clr) begin
         timeout_flag_r <= 1'b1;
      end else if (wr_rctl) begin
         timeout_flag_r <= hwdata[wdt_pkg::TO_BIT];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sleep_flag_r <= 1'b0;
         idle_flag_r  <= 1'b0;
      end else begin
         if (ps_enter && !power_save_idle) begin
            sleep_flag_r <= 1'b1;
         end else if (wr_rctl) begin
            sleep_flag_r <= hwdata[wdt_pkg::SLEEP_BIT];
         end
         if (ps_enter && power_save_idle) begin
            idle_flag_r <= 1'b1;
         end else if (wr_rctl) begin
            idle_flag_r <= hwdata[wdt_pkg::IDLE_BIT];
         end
      end
   end

   // Configuration word, written by software
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg_r <= wdt_pkg::CFG_RST;
      end else if (wr_cfg) begin
         cfg_r <= hwdata[wdt_pkg::CFG_W-1:0];
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // reset on run time-out or early clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         reset_req_r <= 1'b0;
         wake_req_r  <= 1'b0;
      end else begin
         reset_req_r <= (timeout && in_run) || bad_clr;
         wake_req_r  <= timeout && !in_run;
      end
   end

   assign low_power_rc_osc_en = osc_en_r;
   assign wdt_reset_req       = reset_req_r;
   assign wake_req            = wake_req_r;
   assign power_mode          = mode_r;

endmodule

// ### verification/wdt_assertions.sv
// Checker of the watchdog top ports: bus answer, power modes and request pulses
module wdt_assertions (
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // Bus
   input  wire logic        hsel,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic        hready,
   input  wire logic        hreadyout,
   input  wire logic [31:0] hrdata,
   input  wire logic        hresp,
   // Core events and status
   input  wire logic        power_save_instr,
   input  wire logic        power_save_idle,
   input  wire logic        wake_event,
   input  wire logic        low_power_rc_osc_en,
   input  wire logic        wdt_reset_req,
   input  wire logic        wake_req,
   input  wire logic [1:0]  power_mode
);
   timeunit 1ns;
   timeprecision 1ps;
   // --------------------
   // Clocking and sequences
   // --------------------
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   // Running core issues a power-save instruction
   sequence s_enter;
      power_save_instr && power_mode == wdt_pkg::MODE_RUN;
   endsequence
   // Core sits in Sleep or Idle
   sequence s_low;
      power_mode != wdt_pkg::MODE_RUN;
   endsequence
   // --------------------
   // Assertions
   // --------------------
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("Bus answer not ready or not OKAY");
   a_rdata_hold: assert property (!(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata))
      else $error("Read data moved without a read");
   a_enter_mode: assert property (s_enter |=> power_mode ==
      ($past(power_save_idle) ? wdt_pkg::MODE_IDLE : wdt_pkg::MODE_SLEEP))
      else $error("Power-save entry gave the wrong mode");
   a_wake_exit: assert property (power_mode != wdt_pkg::MODE_RUN && wake_event
      |-> ##[1:2] power_mode == wdt_pkg::MODE_RUN)
      else $error("Wake event did not return to run");
   a_wake_from_low: assert property (wake_req |-> $past(power_mode) != wdt_pkg::MODE_RUN)
      else $error("Wake request while running");
   a_wake_return: assert property (wake_req |-> ##[0:2] power_mode == wdt_pkg::MODE_RUN)
      else $error("Time-out wake did not resume run");
   a_wake_osc: assert property (wake_req |-> low_power_rc_osc_en)
      else $error("Wake time-out with oscillator off");
   a_no_reset_low: assert property (s_low ##1 s_low |-> !wdt_reset_req)
      else $error("Reset request during Sleep or Idle");
   a_req_pulse: assert property (wdt_reset_req |=> !wdt_reset_req)
      else $error("Reset request longer than one cycle");
   a_wake_pulse: assert property (wake_req |=> !wake_req)
      else $error("Wake request longer than one cycle");
   c_wake: cover property (s_low ##1 wake_req);
endmodule

bind low_power_rc_osc_watchdog_timer wdt_assertions wdt_assertions_i (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
   .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
   .power_save_instr(power_save_instr), .power_save_idle(power_save_idle),
   .wake_event(wake_event), .low_power_rc_osc_en(low_power_rc_osc_en),
   .wdt_reset_req(wdt_reset_req), .wake_req(wake_req), .power_mode(power_mode));

// ### verification/core_model.sv
// Processor core model: turns bench commands into clear and power-save pulses
module core_model (
   // Clock and reset
   input  wire logic       hclk,
   input  wire logic       hresetn,
   // Bench command and watchdog mode
   input  wire logic [2:0] cmd,
   input  wire logic [1:0] power_mode,
   // Core event lines
   output logic            clear_watchdog_instr,
   output logic            power_save_instr,
   output logic            power_save_idle,
   output logic            wake_event,
   output logic            clock_switch_done
);
   timeunit 1ns;
   timeprecision 1ps;
   logic run;
   logic save;
   // A sleeping core executes nothing
   assign run = power_mode == wdt_pkg::MODE_RUN;
   assign save = cmd == 3'h2 || cmd == 3'h3;
   // Event pulses; the idle select wanders when not qualified
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         clear_watchdog_instr <= 1'b0;
         power_save_instr <= 1'b0;
         power_save_idle <= 1'b0;
         wake_event <= 1'b0;
         clock_switch_done <= 1'b0;
      end else begin
         // clears and power save only while running
         clear_watchdog_instr <= cmd == 3'h1 && run;
         power_save_instr <= save && run;
         power_save_idle <= save ? cmd == 3'h3 : ~power_save_idle;
         wake_event <= cmd == 3'h4;
         clock_switch_done <= cmd == 3'h5;
      end
   end
endmodule

// ### verification/testbench.sv
// Self-checking bench of the watchdog timer top with a core model
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   // --------------------
   // Signals and instances
   // --------------------
   localparam int unsigned TD = 4;
   localparam logic [11:0] CFG_A = wdt_pkg::CFG_OFS;
   localparam logic [11:0] RCTL_A = wdt_pkg::RCTL_OFS;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic clr, ps, psi, wk, sw, low_power_rc_osc_en, wdt_reset_req, wake_req;
   logic [31:0] haddr, hwdata, hrdata, q, seed;
   logic [1:0]  htrans, power_mode;
   logic [2:0]  hsize, cmd;
   int          err_total, n_tests, n_rst, n_wake, n, base;
   low_power_rc_osc_watchdog_timer #(.TICK_DIV(TD)) low_power_rc_osc_watchdog_timer_i (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .clear_watchdog_instr(clr),
      .power_save_instr(ps), .power_save_idle(psi), .wake_event(wk), .clock_switch_done(sw),
      .low_power_rc_osc_en(low_power_rc_osc_en), .wdt_reset_req(wdt_reset_req),
      .wake_req(wake_req), .power_mode(power_mode));
   core_model core_model_i (
      .hclk(hclk), .hresetn(hresetn), .cmd(cmd), .power_mode(power_mode),
      .clear_watchdog_instr(clr), .power_save_instr(ps), .power_save_idle(psi),
      .wake_event(wk), .clock_switch_done(sw));
   // --------------------
   // Helpers
   // --------------------
   function automatic logic [31:0] nx(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [31:0] cfgw(input logic pre, input logic [3:0] post,
                                        input logic [1:0] en, input logic wd,
                                        input logic [1:0] win);
      return 32'(post) | 32'(pre) << wdt_pkg::PRE_BIT | 32'(en) << wdt_pkg::EN_LSB
             | 32'(wd) << wdt_pkg::WINDOW_DISABLE_BIT_BIT | 32'(win) << wdt_pkg::WIN_LSB;
   endfunction
   // Time-out period in clock cycles
   function automatic int pexp(input logic pre, input logic [3:0] post);
      return (1 << ((pre ? 7 : 5) + post)) * TD;
   endfunction
   // Eighths of the period in which a clear is early
   function automatic int closed(input int w);
      return (w == 0) ? 2 : (w == 1) ? 4 : (w == 2) ? 5 : 6;
   endfunction
   task automatic summarize;
      $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // One AHB-Lite single transfer; read data lands in q
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {20'h0_0000, a};
      htrans <= 2'b10;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task automatic arm(input logic [31:0] c);
      bus(1'b1, CFG_A, c);
      bus(1'b1, RCTL_A, 32'h0000_0020);
   endtask
   task automatic ev(input logic [2:0] c);
      @(posedge hclk);
      cmd <= c;
      @(posedge hclk);
      cmd <= 3'h0;
   endtask
   // Cycles until a reset request (w=0) or a wake request (w=1)
   task automatic gap(input bit w);
      n = 0;
      while (((w ? wake_req : wdt_reset_req) !== 1'b1) && n < 20000) begin
         @(posedge hclk);
         n++;
      end
   endtask
   // --------------------
   // Clock, pulse counters, watchdog and main sequence
   // --------------------
   initial begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end
   // Count request pulses as they stand
   always @(posedge hclk) begin
      if (wdt_reset_req === 1'b1) n_rst++;
      if (wake_req === 1'b1) n_wake++;
   end
   initial begin
      #800us;
      err_total++;
      summarize();
   end
   initial begin
      {hresetn, hsel, hwrite, htrans, haddr, hwdata, cmd} = '0;
      hsize = 3'h2;
      seed = 32'h0001_0F48;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      // Reset values and an unmapped word
      bus(1'b0, CFG_A, 0);
      chk(q, 32'h0000_0080);
      bus(1'b0, RCTL_A, 0);
      chk(q, 32'h0000_0000);
      bus(1'b1, 12'h00C, 32'hFFFF_FFFF);
      bus(1'b0, 12'h00C, 0);
      chk(q, 32'h0000_0000);
      // Time-out period over prescale and postscale settings
      for (int i = 0; i < 4; i++) begin
         seed = nx(seed);
         arm(cfgw(i == 2, (i == 3) ? 4'(seed % 3) : 4'(i == 1), wdt_pkg::EN_OFF, 1'b1, 2'b00));
         gap(0);
         base = pexp(i == 2, (i == 3) ? 4'(seed % 3) : 4'(i == 1));
         chk(32'(n >= base - 8 && n <= base + 8), 32'h0000_0001);
         chk(low_power_rc_osc_en, 32'h0000_0001);
         repeat (20) @(posedge hclk);
         bus(1'b0, RCTL_A, 0);
         chk(q, 32'h0000_0030);
         bus(1'b1, RCTL_A, 0);
         bus(1'b0, RCTL_A, 0);
         chk(q, 32'h0000_0000);
      end
      // Regular clears keep a running watchdog from timing out
      arm(cfgw(1'b0, 4'h0, wdt_pkg::EN_SOFT, 1'b1, 2'b00));
      base = n_rst;
      for (int i = 0; i < 6; i++) begin
         seed = nx(seed);
         repeat (40 + seed % 40) @(posedge hclk);
         ev(3'h1);
      end
      chk(n_rst, base);
      // Clock switch and a power-save round trip restart the count
      for (int i = 0; i < 2; i++) begin
         ev(3'h1);
         repeat (100) @(posedge hclk);
         if (i == 0) ev(3'h5);
         else begin
            ev(3'h2);
            ev(3'h4);
         end
         gap(0);
         chk(32'(n > 114 && n < 142), 32'h0000_0001);
      end
      // Time-out in Sleep or Idle wakes the core and leaves its flags
      for (int i = 0; i < 2; i++) begin
         ev(i ? 3'h3 : 3'h2);
         repeat (3) @(posedge hclk);
         chk(power_mode, i ? wdt_pkg::MODE_IDLE : wdt_pkg::MODE_SLEEP);
         gap(1);
         chk(32'(n > 100 && n < 140), 32'h0000_0001);
         repeat (20) @(posedge hclk);
         chk(power_mode, wdt_pkg::MODE_RUN);
         bus(1'b0, RCTL_A, 0);
         chk(q, i ? 32'h0000_0034 : 32'h0000_0038);
         bus(1'b1, RCTL_A, 32'h0000_0020);
      end
      // Field 11 ignores the soft bit, field 01 stops in Sleep
      bus(1'b1, CFG_A, cfgw(1'b0, 4'h0, wdt_pkg::EN_HW, 1'b1, 2'b00));
      bus(1'b1, RCTL_A, 0);
      repeat (3) @(posedge hclk);
      chk(low_power_rc_osc_en, 32'h0000_0001);
      bus(1'b1, CFG_A, cfgw(1'b0, 4'h0, wdt_pkg::EN_ACTIVE, 1'b1, 2'b00));
      base = n_wake;
      ev(3'h2);
      repeat (300) @(posedge hclk);
      bus(1'b0, wdt_pkg::STAT_OFS, 0);
      chk(q, 32'h1000_0000);
      chk(low_power_rc_osc_en, 32'h0000_0000);
      chk(n_wake, base);
      ev(3'h4);
      repeat (3) @(posedge hclk);
      chk(power_mode, wdt_pkg::MODE_RUN);
      chk(low_power_rc_osc_en, 32'h0000_0001);
      bus(1'b1, CFG_A, cfgw(1'b0, 4'h0, wdt_pkg::EN_OFF, 1'b1, 2'b00));
      repeat (3) @(posedge hclk);
      chk(low_power_rc_osc_en, 32'h0000_0000);
      // Each window size: early clear resets, clear in the window does not
      for (int w = 0; w < 4; w++) begin
         for (int late = 0; late < 2; late++) begin
            arm(cfgw(1'b0, 4'h0, wdt_pkg::EN_SOFT, 1'b0, 2'(w)));
            repeat (closed(w) * 16 + (late ? 10 : -14)) @(posedge hclk);
            base = n_rst;
            ev(3'h1);
            repeat (6) @(posedge hclk);
            chk(n_rst - base, late ? 0 : 1);
            bus(1'b1, RCTL_A, 0);
         end
      end
      summarize();
   end
endmodule
